// *** design/tone_pkg.sv ***
package tone_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [15:0] CLK_CTRL_IDX  = 16'h506e;
  localparam logic [15:0] CONTROL_IDX   = 16'h5180;
  localparam logic [15:0] PITCH_IDX     = 16'h5181;
  localparam logic [15:0] DUTY_IDX      = 16'h5182;
  localparam int          ADDR_W        = 20;

  // Field positions
  localparam int GATE_BIT     = 0;  // Clock-gate bit of tone_clock_control
  localparam int RUN_BIT      = 0;  // Run bit of tone_control
  localparam int MODE_LSB     = 2;  // Mode field, two bits
  localparam int DURATION_LSB = 4;  // Duration field, two bits
  localparam int PITCH_LSB    = 0;  // Pitch field, three bits
  localparam int DUTY_LSB     = 0;  // Duty field, three bits

  // Reset values
  localparam logic       GATE_RST     = 1'b0;
  localparam logic       RUN_RST      = 1'b0;
  localparam logic [1:0] MODE_RST     = 2'h0;
  localparam logic [1:0] DURATION_RST = 2'h0;
  localparam logic [2:0] PITCH_RST    = 3'h0;
  localparam logic [2:0] DUTY_RST     = 3'h0;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_NORMAL   = 2'h0,
    MODE_ONESHOT  = 2'h1,
    MODE_ENVELOPE = 2'h2,
    MODE_RESERVED = 2'h3
  } tone_mode_t;

  // Waveform steps come from both edges of the 32.768 kHz clock
  localparam longint TONE_STEP_HZ = 65536;
  localparam longint DUR3_US      = 125000;
  localparam longint DUR2_US      = 62500;
  localparam longint DUR1_US      = 31250;
  localparam longint DUR0_US      = 15630;
  localparam int     DUR_W        = 14;
  // Longest-time figures, rounded down to whole steps
  localparam logic [DUR_W-1:0] DUR3_STEPS = DUR_W'(DUR3_US * TONE_STEP_HZ / 1000000);
  localparam logic [DUR_W-1:0] DUR2_STEPS = DUR_W'(DUR2_US * TONE_STEP_HZ / 1000000);
  localparam logic [DUR_W-1:0] DUR1_STEPS = DUR_W'(DUR1_US * TONE_STEP_HZ / 1000000);
  localparam logic [DUR_W-1:0] DUR0_STEPS = DUR_W'(DUR0_US * TONE_STEP_HZ / 1000000);

  // Waveform shaping: base periods and high counts for the faster four pitches
  localparam logic [5:0] PERIOD_BASE0 = 6'h10;
  localparam logic [5:0] PERIOD_BASE1 = 6'h14;
  localparam logic [5:0] PERIOD_BASE2 = 6'h18;
  localparam logic [5:0] PERIOD_BASE3 = 6'h1c;
  localparam logic [5:0] HIGH_BASE_LO = 6'h08;  // Pitch rows 0,1 at level 0
  localparam logic [5:0] HIGH_BASE_HI = 6'h0c;  // Pitch rows 2,3 at level 0
  localparam logic [2:0] LEVEL_MIN    = 3'h7;
  localparam logic [2:0] LEVEL_MAX    = 3'h0;

  // Settings that shape the waveform
  typedef struct packed {
    logic [2:0] pitch;  // Pitch selection
    logic [2:0] duty;   // Duty level in use
  } tone_shape_t;

endpackage

// *** design/tone_wave.sv ***
`timescale 1ns/1ns
`default_nettype none

// Free-running divider that shapes the tone; never restarted by the run bit
module tone_wave (
  input  wire logic                 pclk,     // System clock
  input  wire logic                 presetn,  // Async reset, active low
  input  wire logic                 step,     // One waveform step
  input  wire tone_pkg::tone_shape_t shape,   // Pitch and duty in use
  output logic                      wave      // Raw tone waveform
);

  logic [5:0] count_q;     // Position within period
  logic [5:0] count_d;     // Next position
  logic [5:0] base_period; // Period for pitch rows 0..3
  logic [5:0] base_high;   // High count at level 0
  logic [5:0] period;      // Period after octave doubling
  logic [5:0] high_cnt;    // High time in steps

  // Lower four pitches double the faster period
  assign base_period = (shape.pitch[1:0] == 2'h0) ? tone_pkg::PERIOD_BASE0 :
                       (shape.pitch[1:0] == 2'h1) ? tone_pkg::PERIOD_BASE1 :
                       (shape.pitch[1:0] == 2'h2) ? tone_pkg::PERIOD_BASE2 :
                                                    tone_pkg::PERIOD_BASE3;
  assign base_high   = shape.pitch[1] ? tone_pkg::HIGH_BASE_HI : tone_pkg::HIGH_BASE_LO;
  assign period      = shape.pitch[2] ? 6'(base_period << 1) : base_period;
  // High time falls one count per level, scaled with the period
  assign high_cnt    = shape.pitch[2] ? 6'((base_high - 6'(shape.duty)) << 1)
                                      : 6'(base_high - 6'(shape.duty));
  // Counter wraps early if pitch shrinks the period mid-cycle
  assign count_d     = (count_q >= period - 6'h01) ? 6'h00 : 6'(count_q + 6'h01);
  assign wave        = (count_q < high_cnt);

  // Step counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_q <= 6'h00;
    else if (step)
      count_q <= count_d;
  end

endmodule
`default_nettype wire

// *** design/buzzer_tone_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Normal mode: run bit gates the tone
// - Waveform not aligned to run changes
// - Pitch and duty apply, normal and one-shot
// - Duration field picks one-shot length
// - Run write starts burst, ends itself
// - Run reads 1 during burst, then clears
// - Writing 0 ends burst at once
// - Writing 1 mid-burst restarts full burst
// - Duration field picks envelope step interval
// - Envelope starts max, steps down, stops
// - Run reads 1 during envelope, then clears
// - Writing 0 stops envelope at once
// - Writing 1 restarts envelope from max
// - Clock-gate bit feeds slow clock, resets off
// - Mode field: normal, one-shot, envelope
// - Pitch field divides to eight tones
// - Duty field sets volume, one count per level, two on the lower four pitches
// - Envelope ignores software duty field
module buzzer_tone_sequencer (
  input  wire logic                        pclk,                // APB clock, 10 MHz
  input  wire logic                        presetn,             // APB reset, active low
  input  wire logic                        psel,                // APB select
  input  wire logic                        penable,             // APB access phase
  input  wire logic                        pwrite,              // APB direction, 1 write
  input  wire logic [tone_pkg::ADDR_W-1:0] paddr,               // APB byte address
  input  wire logic [31:0]                 pwdata,              // APB write data
  output logic      [31:0]                 prdata,              // APB read data
  output logic                             pready,              // APB ready
  output logic                             pslverr,             // APB error, unmapped
  input  wire logic                        low_speed_osc_clock, // 32.768 kHz, sampled
  output logic                             tone_out,            // Buzzer drive
  output logic                             tone_out_n           // Buzzer drive, inverted
);

  // Byte addresses of the registers
  localparam logic [tone_pkg::ADDR_W-1:0] CLK_ADDR  = {2'b00, tone_pkg::CLK_CTRL_IDX, 2'b00};
  localparam logic [tone_pkg::ADDR_W-1:0] CTL_ADDR  = {2'b00, tone_pkg::CONTROL_IDX, 2'b00};
  localparam logic [tone_pkg::ADDR_W-1:0] PIT_ADDR  = {2'b00, tone_pkg::PITCH_IDX, 2'b00};
  localparam logic [tone_pkg::ADDR_W-1:0] DUTY_ADDR = {2'b00, tone_pkg::DUTY_IDX, 2'b00};

  // Software-visible state
  logic                        gate_q;       // Slow clock gate
  logic                        run_q;        // Run bit, trigger and status
  logic                        run_d;        // Next run bit
  tone_pkg::tone_mode_t        mode_q;       // Operating mode
  logic [1:0]                  duration_q;   // Duration or step interval select
  logic [2:0]                  pitch_q;      // Pitch select
  logic [2:0]                  duty_q;       // Software duty level

  // Sequencer state
  logic [tone_pkg::DUR_W-1:0]  dur_cnt_q;    // Steps elapsed in burst or interval
  logic [tone_pkg::DUR_W-1:0]  dur_cnt_d;    // Next elapsed count
  logic [2:0]                  env_level_q;  // Envelope duty level
  logic [2:0]                  env_level_d;  // Next envelope level
  logic                        osc_prev_q;   // Last sampled slow clock

  // Bus registers
  logic [31:0]                 prdata_q;     // Read data captured at setup
  logic                        pready_q;     // One-cycle ready
  logic                        pslverr_q;    // Unmapped flag
  logic                        tone_q;       // Registered tone drive
  logic                        tone_n_q;     // Registered inverted drive

  // Decode and strobes
  logic                        setup;        // Setup phase of a transfer
  logic                        wr_en;        // Write takes effect now
  logic                        hit_clk;      // Address is clock register
  logic                        hit_ctl;      // Address is control register
  logic                        hit_pit;      // Address is pitch register
  logic                        hit_duty;     // Address is duty register
  logic                        mapped;       // Any register hit
  logic [7:0]                  rd_mux;       // Read value of addressed register
  logic                        wr_ctl;       // Control register write
  logic                        trig;         // Run written to 1
  logic                        step;         // One waveform step
  logic                        timed;        // Burst or envelope mode
  logic [tone_pkg::DUR_W-1:0]  dur_limit;    // Steps in selected time
  logic                        interval_end; // Burst or interval completes
  logic                        done;         // Sequence finished by hardware
  logic                        sounding;     // Tone allowed onto pin
  logic                        wave;         // Raw waveform
  logic                        tone_d;       // Next tone drive
  tone_pkg::tone_shape_t       shape;        // Settings to the divider

  // Address decoding
  assign setup    = psel & ~penable;
  assign wr_en    = psel & penable & pready_q & pwrite;
  assign hit_clk  = (paddr == CLK_ADDR);
  assign hit_ctl  = (paddr == CTL_ADDR);
  assign hit_pit  = (paddr == PIT_ADDR);
  assign hit_duty = (paddr == DUTY_ADDR);
  assign mapped   = hit_clk | hit_ctl | hit_pit | hit_duty;

  // Read data; reserved bits read as zero
  assign rd_mux = hit_clk  ? {7'h00, gate_q} :
                  hit_ctl  ? {2'b00, duration_q, mode_q, 1'b0, run_q} :
                  hit_pit  ? {5'h00, pitch_q} :
                  hit_duty ? {5'h00, duty_q} :
                             8'h00;

  // Control strobes; a write of 1 is the trigger in every mode
  assign wr_ctl = wr_en & hit_ctl;
  assign trig   = wr_ctl & pwdata[tone_pkg::RUN_BIT];

  // Slow clock steps only while the gate is open; both edges count
  assign step  = gate_q & (low_speed_osc_clock ^ osc_prev_q);
  assign timed = (mode_q == tone_pkg::MODE_ONESHOT) | (mode_q == tone_pkg::MODE_ENVELOPE);

  // Burst length or envelope interval from the duration field
  assign dur_limit = (duration_q == 2'h3) ? tone_pkg::DUR3_STEPS :
                     (duration_q == 2'h2) ? tone_pkg::DUR2_STEPS :
                     (duration_q == 2'h1) ? tone_pkg::DUR1_STEPS :
                                            tone_pkg::DUR0_STEPS;

  assign interval_end = run_q & timed & step & (dur_cnt_q == dur_limit - 1'b1);

  // One-shot ends after one interval; envelope after the last level
  assign done = interval_end &
                ((mode_q == tone_pkg::MODE_ONESHOT) |
                 (env_level_q == tone_pkg::LEVEL_MIN));

  // Software write wins over a hardware clear in the same cycle
  assign run_d = wr_ctl ? pwdata[tone_pkg::RUN_BIT] :
                 done   ? 1'b0 :
                          run_q;

  // Elapsed counter: restarts on trigger, idles at zero
  assign dur_cnt_d = (trig | ~run_q) ? '0 :
                     interval_end    ? '0 :
                     step            ? tone_pkg::DUR_W'(dur_cnt_q + 1'b1) :
                                       dur_cnt_q;

  // Envelope level: maximum on trigger, one step down per interval
  assign env_level_d = trig ? tone_pkg::LEVEL_MAX :
                       (interval_end & (mode_q == tone_pkg::MODE_ENVELOPE) &
                        (env_level_q != tone_pkg::LEVEL_MIN)) ? 3'(env_level_q + 3'h1) :
                       env_level_q;

  // Envelope takes the hardware level, others take software duty
  assign shape.pitch = pitch_q;
  assign shape.duty  = (mode_q == tone_pkg::MODE_ENVELOPE) ? env_level_q : duty_q;

  // Reserved mode stays silent; a closed gate mutes the pin
  assign sounding = run_q & gate_q & (mode_q != tone_pkg::MODE_RESERVED);

  // Waveform gated straight by run, no alignment to its period
  assign tone_d = sounding & wave;

  // Waveform divider
  tone_wave u_wave (
    .pclk    (pclk),
    .presetn (presetn),
    .step    (step),
    .shape   (shape),
    .wave    (wave)
  );

  // Configuration registers; reserved bits are dropped on write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gate_q     <= tone_pkg::GATE_RST;
      mode_q     <= tone_pkg::tone_mode_t'(tone_pkg::MODE_RST);
      duration_q <= tone_pkg::DURATION_RST;
      pitch_q    <= tone_pkg::PITCH_RST;
      duty_q     <= tone_pkg::DUTY_RST;
    end
    else if (wr_en)
    begin
      // Software must leave reserved bits at zero; they are not stored
      if (hit_clk)
        gate_q <= pwdata[tone_pkg::GATE_BIT];
      else if (hit_ctl)
      begin
        mode_q     <= tone_pkg::tone_mode_t'(pwdata[tone_pkg::MODE_LSB +: 2]);
        duration_q <= pwdata[tone_pkg::DURATION_LSB +: 2];
      end
      else if (hit_pit)
        pitch_q <= pwdata[tone_pkg::PITCH_LSB +: 3];
      else if (hit_duty)
        duty_q <= pwdata[tone_pkg::DUTY_LSB +: 3];
    end
  end

  // Sequencer state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q       <= tone_pkg::RUN_RST;
      dur_cnt_q   <= '0;
      env_level_q <= tone_pkg::LEVEL_MAX;
      osc_prev_q  <= 1'b0;
    end
    else
    begin
      run_q       <= run_d;
      dur_cnt_q   <= dur_cnt_d;
      env_level_q <= env_level_d;
      osc_prev_q  <= low_speed_osc_clock;
    end
  end

  // Bus answer: data captured at setup, ready for one access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup)
        prdata_q <= {24'h00_0000, rd_mux};
    end
  end

  // Pin drive; both pins from one term so they never overlap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tone_q   <= 1'b0;
      tone_n_q <= 1'b1;
    end
    else
    begin
      tone_q   <= tone_d;
      tone_n_q <= ~tone_d;
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign tone_out   = tone_q;
  assign tone_out_n = tone_n_q;

endmodule
`default_nettype wire

// *** dv/tone_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
// Bus and pin checks, seeing only the top ports
module tone_assertions (
  input wire logic                        pclk,       // Clock
  input wire logic                        presetn,    // Reset, active low
  input wire logic                        psel,       // Select
  input wire logic                        penable,    // Access phase
  input wire logic                        pwrite,     // Direction
  input wire logic [tone_pkg::ADDR_W-1:0] paddr,      // Byte address
  input wire logic [31:0]                 pwdata,     // Write data
  input wire logic [31:0]                 prdata,     // Read data
  input wire logic                        pready,     // Ready
  input wire logic                        pslverr,    // Error
  input wire logic                        tone_out,   // Drive
  input wire logic                        tone_out_n  // Drive, inverted
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Word decode; upper and lowest bits must be clear
  wire [15:0] idx    = paddr[17:2];
  wire        lo_ok  = paddr[19:18] == 2'h0 && paddr[1:0] == 2'h0;
  wire        setup  = psel && !penable;
  wire        mapped = lo_ok && (idx == tone_pkg::CLK_CTRL_IDX || idx == tone_pkg::CONTROL_IDX ||
                       idx == tone_pkg::PITCH_IDX || idx == tone_pkg::DUTY_IDX);
  // Completed write that clears the run bit
  wire        stop   = psel && penable && pready && pwrite && lo_ok && idx == tone_pkg::CONTROL_IDX && !pwdata[0];

  answer_next_a: assert property (setup |=> pready) else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
  mapped_ok_a: assert property (setup && mapped |=> !pslverr) else $error("error on a mapped word");
  unmapped_err_a: assert property (setup && !mapped && !pwrite |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  read_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000) else $error("upper bits set");
  pin_pair_a: assert property (tone_out_n == !tone_out) else $error("pins not complementary");
  pin_move_a: assert property ($changed(tone_out) |-> $changed(tone_out_n)) else $error("pins moved apart");
  stop_write_a: assert property (stop |-> ##2 (!tone_out) [*2]) else $error("tone after stop");
  reset_idle_a: assert property ($rose(presetn) |-> !tone_out && tone_out_n) else $error("not idle at reset");
endmodule

bind buzzer_tone_sequencer tone_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tone_out(tone_out), .tone_out_n(tone_out_n));
`default_nettype wire

// *** dv/piezo_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Piezo element across both drive pins; it only listens and times the swing
module piezo_model (
  input  wire logic        pclk,    // Time base
  input  wire logic        drive,   // Non-inverted pin
  input  wire logic        drive_n, // Inverted pin
  output logic [31:0]      rises,   // Swings seen so far
  output logic [31:0]      period,  // Last rise to rise, pclk
  output logic [31:0]      high     // Last high time, pclk
);
  logic [31:0] per_q;  // Time since last rise
  logic [31:0] hi_q;   // High time of this swing
  logic        last_q; // Previous state
  // Driven only when drive is high and drive_n low, as the element sees it
  wire         across = drive & ~drive_n;
  initial
  begin
    {rises, period, high, per_q, hi_q} = 160'h0;
    last_q = 1'b0;
  end
  // Period is latched before the count moves, so a reader never sees a stale pair
  always @(posedge pclk)
  begin
    if (across && !last_q)
    begin
      period = per_q;
      per_q  = 0;
      hi_q   = 0;
      rises  = rises + 1;
    end
    if (!across && last_q)
      high = hi_q;
    per_q  = per_q + 1;
    hi_q   = hi_q + 32'(across);
    last_q = across;
  end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the buzzer tone sequencer
module tb_top;
  localparam logic [19:0] A_CLK = 20'({tone_pkg::CLK_CTRL_IDX, 2'b00}); // Gate word
  localparam logic [19:0] A_CTL = 20'({tone_pkg::CONTROL_IDX, 2'b00});  // Control word
  localparam logic [19:0] A_PIT = 20'({tone_pkg::PITCH_IDX, 2'b00});    // Pitch word
  localparam logic [19:0] A_DUT = 20'({tone_pkg::DUTY_IDX, 2'b00});     // Duty word
  localparam int          M     = 32;    // Slack for synchroniser and bus
  localparam int          LIMIT = 90000; // Run ceiling
  logic        pclk, presetn, psel, penable, pwrite, osc, pready, pslverr, tone_out, tone_out_n;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, rises, period, high;
  logic [32:0] exp_q[$];  // Expected {error, data}, oldest first
  logic [7:0]  lfsr_q;    // Random source
  int          cyc = 0, n_errors = 0, compares = 0, t0, r0;

  buzzer_tone_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_speed_osc_clock(osc), .tone_out(tone_out), .tone_out_n(tone_out_n));
  piezo_model buzz (.pclk(pclk), .drive(tone_out), .drive_n(tone_out_n), .rises(rises), .period(period), .high(high));

  // 10 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Cycle count, fast slow clock (one step per two pclk) and hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    osc <= osc ^ cyc[0];
    if (cyc == LIMIT)
    begin
      n_errors++;
      summarize();
    end
  end
  // Each completed transfer retires the oldest note
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      cmp("pslverr", 32'(exp_q[0][32]), 32'(pslverr));
      if (!pwrite)
        cmp("prdata", exp_q[0][31:0], prdata);
      void'(exp_q.pop_front());
    end

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Period and high time in pclk for a pitch and level
  function automatic int f_per(input int p);
    return (16 + 4 * (p % 4)) * (p / 4 + 1) * 2;
  endfunction
  function automatic int f_hi(input int p, input int d);
    return ((p % 4 < 2 ? 8 : 12) - d) * (p / 4 + 1) * 2;
  endfunction
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One bus cycle; request held until ready is sampled high
  task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h00_0000, d}, 33'h0_0000_0000);
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] d);
    xfer(1'b0, a, 32'h0000_0000, {9'h000, 16'h0000, d});
  endtask
  task automatic wait_to(input int t);
    while (cyc < t)
      @(posedge pclk);
  endtask
  // Third swing after a change is wholly under the new setting
  task automatic measure(input int p, input int h);
    r0 = rises;
    while (rises < r0 + 3)
      @(posedge pclk);
    cmp("period", p, period);
    cmp("high", h, high);
  endtask
  // A swing launched just before the stop may still reach the element; let it land first
  task automatic quiet();
    repeat (4) @(posedge pclk);
    r0 = rises;
    repeat (200) @(posedge pclk);
    cmp("rises", r0, rises);
    cmp("level", 32'h0000_0000, 32'(tone_out));
  endtask
  task automatic summarize();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    {psel, penable, pwrite, osc, presetn} = 5'h00;
    paddr  = 20'h0_0000;
    pwdata = 32'h0000_0000;
    lfsr_q = 8'h1e;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CLK, 8'h00);
    rd(A_CTL, 8'h00);
    rd(A_PIT, 8'h00);
    rd(A_DUT, 8'h00);
    xfer(1'b1, 20'h0_1000, 32'h0000_00ff, 33'h1_0000_0000);
    xfer(1'b0, 20'h0_1000, 32'h0000_0000, 33'h1_0000_0000);
    // Reserved bits always written as zero
    wr(A_CLK, 8'h00);
    rd(A_CLK, 8'h00);
    wr(A_CTL, 8'h3c);
    rd(A_CTL, 8'h3c);
    wr(A_CTL, 8'h01);
    quiet();
    $display("registers and gate done");
    wr(A_CLK, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      wr(A_PIT, 8'(i));
      wr(A_DUT, 8'(7 - i));
      measure(f_per(i), f_hi(i, 7 - i));
    end
    wr(A_CTL, 8'h0d);
    quiet();
    wr(A_CTL, 8'h00);
    quiet();
    $display("normal mode done");
    for (int d = 0; d < 4; d++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      wr(A_PIT, {5'h00, lfsr_q[2:0]});
      wr(A_DUT, {5'h00, lfsr_q[5:3]});
      wr(A_CTL, 8'(d * 16 + 5));
      t0 = cyc;
      measure(f_per(lfsr_q[2:0]), f_hi(lfsr_q[2:0], lfsr_q[5:3]));
      if (d == 0)
      begin
        wait_to(t0 + 1024);
        wr(A_CTL, 8'h05);
        t0 = cyc;
      end
      wait_to(t0 + (2048 << d) - M);
      rd(A_CTL, 8'(d * 16 + 5));
      wait_to(t0 + (2048 << d) + M);
      rd(A_CTL, 8'(d * 16 + 4));
    end
    wr(A_CTL, 8'h35);
    repeat (300) @(posedge pclk);
    wr(A_CTL, 8'h34);
    rd(A_CTL, 8'h34);
    quiet();
    $display("one-shot mode done");
    wr(A_PIT, 8'h00);
    wr(A_DUT, 8'h07);
    wr(A_CTL, 8'h09);
    t0 = cyc;
    measure(32, 16);
    wait_to(t0 + 5120);
    wr(A_CTL, 8'h09);
    t0 = cyc;
    measure(32, 16);
    wait_to(t0 + 7168);
    measure(32, 10);
    wait_to(t0 + 16384 - M);
    rd(A_CTL, 8'h09);
    wait_to(t0 + 16384 + M);
    rd(A_CTL, 8'h08);
    quiet();
    wr(A_CTL, 8'h09);
    repeat (300) @(posedge pclk);
    wr(A_CTL, 8'h08);
    rd(A_CTL, 8'h08);
    quiet();
    $display("envelope mode done");
    summarize();
  end
endmodule
`default_nettype wire
